// *** apsc_device.sv ***
// register bank: pin status, codec reflection and audio clock programming
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// - bit 20 enables programmed CTS/M values
// - bits 19:0 hold programmable CTS value
// - software also writes bit 21 when programming
// - software disables transcoder before changing field
// - idle bit: attached but not streaming
// - merge audio when enabled, active, available
// - output enable reported to codec as presence
// - ready bit: 0 pending, 1 ready
// - software writes ready 1 after servicing
// - software waits 1ms before ready update
// - ready update sends unsolicited response, after earlier
// - software sets info valid after storing data
// - software clears info valid on init, hotplug
// - info valid reflected to codec pin widget
// - independent bit set per transcoder
// - transcoder A bits at 3, 2, 1, 0
// - bit 21 selects CTS or M view
module apsc_device
  import apsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  apsc_if.dev              bus,
  input  wire logic [2:0]  audioAvail,
  input  wire logic [2:0]  cpRequest,
  input  wire logic        unsolReady,
  output logic [2:0]       audioMerge,
  output logic [2:0]       presence,
  output logic [2:0]       sinkInfoValid,
  output logic [2:0]       protectReady,
  output logic             unsolValid,
  output logic [7:0]       unsolData,
  output logic             clkProgEnable,
  output logic             clkValSel,
  output logic [19:0]      ctsValue,
  output logic [19:0]      mValue
);
  import apsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  apsc_dev_st_t s_reg;
  apsc_dev_st_t s_next;

  logic         take;
  logic         wrPin;
  logic         wrClk;
  logic         hitPin;
  logic         hitClk;
  logic [11:0]  pinNew;
  logic [2:0]   eldEv;
  logic [2:0]   cpEv;
  logic [2:0]   pickE;
  logic [2:0]   pickC;
  logic         found;
  int           b;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    b      = 0;
    pickE  = 3'h0;
    pickC  = 3'h0;
    found  = 1'b0;
    eldEv  = 3'h0;
    cpEv   = 3'h0;
    take   = bus.req && !s_reg.ack;
    hitPin = bus.addr == PIN_STATUS_OFS;
    hitClk = bus.addr == CLK_PROG_OFS;
    wrPin  = take && bus.wr && hitPin;
    wrClk  = take && bus.wr && hitClk;

    // one-cycle acknowledge for each request
    s_next.ack = take;
    s_next.err = take && !hitPin && !hitClk;
    if (take)
    begin
      if (hitPin)
        s_next.rdata = {20'h00000, s_reg.pin};
      else if (hitClk)
        s_next.rdata = {10'h000, s_reg.sel, s_reg.en,
                        s_reg.sel ? s_reg.m : s_reg.cts};
      else
        s_next.rdata = 32'h00000000;
    end

    // ----------------------------------------------------------------
    // pin status: software write, then audio unit requests
    // ----------------------------------------------------------------
    pinNew = wrPin ? bus.wdata[PIN_USED-1:0] : s_reg.pin;
    for (int t = 0; t < NUM_TC; t++)
    begin
      b = t * TC_STRIDE;
      if (cpRequest[t])
        pinNew[b+READY_POS] = 1'b0;
      cpEv[t]  = pinNew[b+READY_POS] != s_reg.pin[b+READY_POS];
      eldEv[t] = (pinNew[b+ELD_POS] != s_reg.pin[b+ELD_POS])
              || (pinNew[b+OUTON_POS] != s_reg.pin[b+OUTON_POS]);
      s_next.merge[t] = s_reg.pin[b+OUTON_POS] && !s_reg.pin[b+IDLE_POS]
                     && audioAvail[t];
    end
    s_next.pin = pinNew;

    // ----------------------------------------------------------------
    // unsolicited responses: presence/info changes drain before ready
    // ----------------------------------------------------------------
    if (s_reg.uValid && unsolReady)
      s_next.uValid = 1'b0;
    if (!s_reg.uValid || unsolReady)
    begin
      for (int t = 0; t < NUM_TC; t++)
      begin
        if (!found && s_reg.eldPend[t])
        begin
          found    = 1'b1;
          pickE[t] = 1'b1;
        end
      end
      for (int t = 0; t < NUM_TC; t++)
      begin
        if (!found && s_reg.cpPend[t])
        begin
          found    = 1'b1;
          pickC[t] = 1'b1;
        end
      end
      for (int t = 0; t < NUM_TC; t++)
      begin
        b = t * TC_STRIDE;
        if (pickE[t] || pickC[t])
        begin
          s_next.uValid = 1'b1;
          s_next.uData  = {pickC[t] ? UNSOL_CP : UNSOL_PD_ELD, t[1:0],
                           s_reg.pin[b+IDLE_POS], s_reg.pin[b+OUTON_POS],
                           s_reg.pin[b+READY_POS], s_reg.pin[b+ELD_POS]};
        end
      end
    end
    // a new event in the pick cycle stays pending
    s_next.eldPend = (s_reg.eldPend & ~pickE) | eldEv;
    s_next.cpPend  = (s_reg.cpPend & ~pickC) | cpEv;

    // ----------------------------------------------------------------
    // audio clock programming
    // ----------------------------------------------------------------
    if (wrClk)
    begin
      s_next.sel = bus.wdata[CLK_SEL_POS];
      s_next.en  = bus.wdata[CLK_EN_POS];
      if (bus.wdata[CLK_SEL_POS])
        s_next.m = bus.wdata[CTS_W-1:0];
      else
        s_next.cts = bus.wdata[CTS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '{ack: 1'b0, err: 1'b0, rdata: 32'h00000000, pin: PIN_RESET,
                 sel: 1'b0, en: 1'b0, cts: CTS_RESET, m: CTS_RESET,
                 merge: 3'h0, eldPend: 3'h0, cpPend: 3'h0,
                 uValid: 1'b0, uData: 8'h00};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.ack       = s_reg.ack;
  assign bus.err       = s_reg.err;
  assign bus.rdata     = s_reg.rdata;
  assign audioMerge    = s_reg.merge;
  assign unsolValid    = s_reg.uValid;
  assign unsolData     = s_reg.uData;
  assign clkProgEnable = s_reg.en;
  assign clkValSel     = s_reg.sel;
  assign ctsValue      = s_reg.cts;
  assign mValue        = s_reg.m;

  // ----------------------------------------------------------------
  // codec reflection
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_TC; g++)
    begin : gTc
      assign presence[g]      = s_reg.pin[g*TC_STRIDE+OUTON_POS];
      assign sinkInfoValid[g] = s_reg.pin[g*TC_STRIDE+ELD_POS];
      assign protectReady[g]  = s_reg.pin[g*TC_STRIDE+READY_POS];
    end
  endgenerate

endmodule : apsc_device

// *** apsc_pkg.sv ***
// shared constants and types for the audio pin status and clock programming block
package apsc_pkg;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 20;
  localparam logic [19:0] PIN_STATUS_OFS = 20'h650c0;
  localparam logic [19:0] CLK_PROG_OFS   = 20'h65028;

  // ----------------------------------------------------------------
  // pin status layout, one nibble per transcoder
  // ----------------------------------------------------------------
  localparam int          NUM_TC      = 3;
  localparam int          TC_STRIDE   = 4;
  localparam int          ELD_POS     = 0;
  localparam int          READY_POS   = 1;
  localparam int          OUTON_POS   = 2;
  localparam int          IDLE_POS    = 3;
  localparam int          PIN_USED    = 12;
  localparam logic [11:0] PIN_RESET   = 12'h000;

  // ----------------------------------------------------------------
  // audio clock programming layout
  // ----------------------------------------------------------------
  localparam int          CTS_W       = 20;
  localparam int          CLK_EN_POS  = 20;
  localparam int          CLK_SEL_POS = 21;
  localparam logic [19:0] CTS_RESET   = 20'h00000;

  // ----------------------------------------------------------------
  // unsolicited response message
  // ----------------------------------------------------------------
  localparam logic [1:0]  UNSOL_PD_ELD = 2'h1;
  localparam logic [1:0]  UNSOL_CP     = 2'h2;

  // ----------------------------------------------------------------
  // controller register map (axi4-lite, byte addresses)
  // ----------------------------------------------------------------
  localparam int          AXI_AW       = 8;
  localparam logic [7:0]  H_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  H_ADDR_OFS   = 8'h04;
  localparam logic [7:0]  H_WDATA_OFS  = 8'h08;
  localparam logic [7:0]  H_RDATA_OFS  = 8'h0c;
  localparam logic [7:0]  H_STAT_OFS   = 8'h10;
  localparam logic [7:0]  H_IRQ_OFS    = 8'h14;
  localparam logic [7:0]  H_MASK_OFS   = 8'h18;
  localparam int          CTRL_GO_POS  = 0;
  localparam int          CTRL_WR_POS  = 1;
  localparam int          IRQ_DONE_POS = 0;
  localparam int          IRQ_ERR_POS  = 1;
  localparam int          IRQ_W        = 2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_REQ  = 2'b10
  } apsc_hstate_t;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [31:0]       rdata;
    logic [11:0]       pin;
    logic              sel;
    logic              en;
    logic [19:0]       cts;
    logic [19:0]       m;
    logic [2:0]        merge;
    logic [2:0]        eldPend;
    logic [2:0]        cpPend;
    logic              uValid;
    logic [7:0]        uData;
  } apsc_dev_st_t;

  typedef struct packed {
    apsc_hstate_t      st;
    logic              awHave;
    logic [7:0]        awAddr;
    logic              wHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              wrFlag;
    logic [19:0]       addr;
    logic [31:0]       wdat;
    logic [31:0]       rdat;
    logic [1:0]        irqStat;
    logic [1:0]        irqMask;
    logic              irq;
    logic              awRdy;
    logic              wRdy;
    logic              arRdy;
  } apsc_host_st_t;

endpackage : apsc_pkg

// *** apsc_if.sv ***
// register access link between controller and register bank
`timescale 1ns/1ps
interface apsc_if;
  import apsc_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic              ack;
  logic              err;
  logic [31:0]       rdata;

  modport dev  (input req, wr, addr, wdata, output ack, err, rdata);
  modport host (output req, wr, addr, wdata, input ack, err, rdata);
endinterface : apsc_if

// *** apsc_host.sv ***
// controller: axi4-lite register front end issuing register bank accesses
`timescale 1ns/1ps
module apsc_host
  import apsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  apsc_if.host             bus
);
  import apsc_pkg::*;

  apsc_host_st_t s_reg;
  apsc_host_st_t s_next;
  logic [1:0]    irqSet;
  logic          doWr;

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction : mrg

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    irqSet = 2'h0;
    doWr   = s_reg.awHave && s_reg.wHave && !s_reg.bvalid;

    if (s_axi_awvalid && s_reg.awRdy)
    begin
      s_next.awHave = 1'b1;
      s_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wRdy)
    begin
      s_next.wHave = 1'b1;
      s_next.wData = s_axi_wdata;
      s_next.wStrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;

    // link transaction end
    if (s_reg.st == H_REQ && bus.ack)
    begin
      s_next.st   = H_IDLE;
      s_next.rdat = bus.rdata;
      irqSet[IRQ_DONE_POS] = 1'b1;
      irqSet[IRQ_ERR_POS]  = bus.err;
    end

    if (doWr)
    begin
      s_next.awHave = 1'b0;
      s_next.wHave  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      unique case (s_reg.awAddr)
        H_CTRL_OFS:
        begin
          // software keeps ordering duties: bit 21 with the value, transcoder off,
          // ready written back after the wait, info valid set and cleared
          if (s_reg.wStrb[0] && s_reg.wData[CTRL_GO_POS] && s_reg.st == H_IDLE)
          begin
            s_next.st     = H_REQ;
            s_next.wrFlag = s_reg.wData[CTRL_WR_POS];
          end
        end
        H_ADDR_OFS:  s_next.addr    = 20'(mrg({12'h000, s_reg.addr}, s_reg.wData, s_reg.wStrb));
        H_WDATA_OFS: s_next.wdat    = mrg(s_reg.wdat, s_reg.wData, s_reg.wStrb);
        H_MASK_OFS:  s_next.irqMask = s_reg.wStrb[0] ? s_reg.wData[IRQ_W-1:0] : s_reg.irqMask;
        H_RDATA_OFS, H_STAT_OFS, H_IRQ_OFS: s_next.bresp = RESP_OKAY;
        default:     s_next.bresp   = RESP_SLVERR;
      endcase
    end

    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.arRdy)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = 32'h00000000;
      unique case (s_axi_araddr)
        H_CTRL_OFS:  s_next.rdata = {30'h0, s_reg.wrFlag, 1'b0};
        H_ADDR_OFS:  s_next.rdata = {12'h000, s_reg.addr};
        H_WDATA_OFS: s_next.rdata = s_reg.wdat;
        H_RDATA_OFS: s_next.rdata = s_reg.rdat;
        H_STAT_OFS:  s_next.rdata = {31'h0, s_reg.st == H_REQ};
        H_IRQ_OFS:
        begin
          s_next.rdata   = {30'h0, s_reg.irqStat};
          s_next.irqStat = 2'h0;
        end
        H_MASK_OFS:  s_next.rdata = {30'h0, s_reg.irqMask};
        default:     s_next.rresp = RESP_SLVERR;
      endcase
    end
    // a new event beats the read clear
    s_next.irqStat = s_next.irqStat | irqSet;
    s_next.irq     = |(s_next.irqStat & s_next.irqMask);
    // ready flags registered so every AXI port leaves a flop; bus.req is decoded from st
    s_next.awRdy   = !s_next.awHave && !s_next.bvalid;
    s_next.wRdy    = !s_next.wHave && !s_next.bvalid;
    s_next.arRdy   = !s_next.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_reg <= '{st: H_IDLE, awAddr: 8'h00, wData: 32'h0, wStrb: 4'h0,
                 bresp: 2'h0, rdata: 32'h0, rresp: 2'h0, addr: 20'h0,
                 wdat: 32'h0, rdat: 32'h0, irqStat: 2'h0, irqMask: 2'h0,
                 default: 1'b0};
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_reg.awRdy;
  assign s_axi_wready  = s_reg.wRdy;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arRdy;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign irq           = s_reg.irq;
  assign bus.req       = s_reg.st == H_REQ;
  assign bus.wr        = s_reg.wrFlag;
  assign bus.addr      = s_reg.addr;
  assign bus.wdata     = s_reg.wdat;

endmodule : apsc_host

// *** apsc_link_properties.sv ***
// protocol checker for the register bank access link
`timescale 1ns/1ps
module apsc_link_properties
(
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire logic                      req,
  input wire logic                      wr,
  input wire logic [apsc_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0]               wdata,
  input wire logic                      ack,
  input wire logic                      err,
  input wire logic [31:0]               rdata
);
  import apsc_pkg::*;
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic mapped;
  assign mapped = (addr == PIN_STATUS_OFS) || (addr == CLK_PROG_OFS);
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !req;
  endsequence
  chk_ack_answer: assert property (s_taken |=> s_answer)
    else $error("link answer not one cycle after request");
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  chk_ack_cause: assert property (ack |-> $past(req && !ack))
    else $error("link ack without request");
  chk_req_hold: assert property (s_taken |=> $stable(addr) && $stable(wr)
                                 && $stable(wdata))
    else $error("link request changed while open");
  chk_req_gap: assert property ($fell(req) |=> !req)
    else $error("link requests too close");
  chk_err_unmapped: assert property (ack |-> err == !mapped)
    else $error("link error flag wrong for address");
  chk_err_rdata: assert property (ack && err |-> rdata == 32'h0)
    else $error("refused access returned data");
  chk_pin_rsvd: assert property (ack && !wr && addr == PIN_STATUS_OFS
                                 |-> rdata[31:12] == 20'h0)
    else $error("pin status reserved bits not zero");
  chk_clk_rsvd: assert property (ack && !wr && addr == CLK_PROG_OFS
                                 |-> rdata[31:22] == 10'h0)
    else $error("clock program reserved bits not zero");
endmodule : apsc_link_properties

// *** apsc_tb.sv ***
// self-checking testbench for controller and register bank
`timescale 1ns/1ps
module apsc_tb;
  import apsc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rv;
  logic [2:0]  avail = 3'h0, cpReq = 3'h0;
  logic        uRdy = 1'b1;
  logic [2:0]  merge, pres, infoV, protRdy;
  logic        uValid, clkEn, clkSel;
  logic [7:0]  uData;
  logic [19:0] cts, mVal;
  logic [7:0]  msgs[$];
  int          n_fail = 0, n_checks = 0, cycles = 0;

  always #20 clk = ~clk;
  apsc_if i_apsc_if ();
  apsc_device i_apsc_device (.clk(clk), .rstn(rstn), .bus(i_apsc_if.dev),
    .audioAvail(avail), .cpRequest(cpReq), .unsolReady(uRdy), .audioMerge(merge),
    .presence(pres), .sinkInfoValid(infoV), .protectReady(protRdy), .unsolValid(uValid),
    .unsolData(uData), .clkProgEnable(clkEn), .clkValSel(clkSel), .ctsValue(cts),
    .mValue(mVal));
  apsc_host i_apsc_host (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .bus(i_apsc_if.host));
  apsc_link_properties i_apsc_link_properties (.clk(clk), .rstn(rstn),
    .req(i_apsc_if.req), .wr(i_apsc_if.wr), .addr(i_apsc_if.addr),
    .wdata(i_apsc_if.wdata), .ack(i_apsc_if.ack), .err(i_apsc_if.err),
    .rdata(i_apsc_if.rdata));

  // ----------------------------------------------------------------
  // monitors and helpers
  // ----------------------------------------------------------------
  always @(negedge clk)
    if (uValid === 1'b1 && uRdy)
      msgs.push_back(uData);
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) break;
    end
    rready <= 1'b0;
  endtask : axi_rd
  task automatic dev_op(input logic [19:0] a, input logic [31:0] d, input logic wr);
    axi_wr(H_ADDR_OFS, {12'h000, a});
    if (wr) axi_wr(H_WDATA_OFS, d);
    axi_wr(H_CTRL_OFS, {30'h0, wr, 1'b1});
    forever
    begin
      axi_rd(H_STAT_OFS);
      if (rv[0] === 1'b0) break;
    end
    if (!wr) axi_rd(H_RDATA_OFS);
  endtask : dev_op

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    dev_op(PIN_STATUS_OFS, 32'h0, 1'b0);
    check(rv, 32'h0);
    check({19'h0, merge, pres, infoV, protRdy, uValid}, 32'h0);
    dev_op(CLK_PROG_OFS, 32'h0, 1'b0);
    check(rv, 32'h0);
  endtask : s_reset
  task automatic s_pin;
    avail <= 3'h7;
    dev_op(PIN_STATUS_OFS, 32'hffffffff, 1'b1);
    dev_op(PIN_STATUS_OFS, 32'h0, 1'b0);
    check(rv, 32'h00000fff);
    check({20'h0, pres, infoV, protRdy, merge}, 32'hff8);
    dev_op(PIN_STATUS_OFS, 32'h421, 1'b1);
    dev_op(PIN_STATUS_OFS, 32'h0, 1'b0);
    check(rv, 32'h421);
    check({20'h0, pres, infoV, protRdy, merge}, 32'h854);
    avail <= 3'h3;
    repeat (3) @(negedge clk);
    check({29'h0, merge}, 32'h0);
    msgs.delete();
  endtask : s_pin
  task automatic s_unsol;
    logic [7:0] exp [4];
    exp = '{8'h51, 8'h60, 8'h83, 8'h91};
    @(posedge clk);
    uRdy <= 1'b0;
    dev_op(PIN_STATUS_OFS, 32'h013, 1'b1);
    check({31'h0, uValid}, 32'h1);
    check({23'h0, pres, infoV, protRdy}, 32'h019);
    uRdy <= 1'b1;
    repeat (12) @(negedge clk);
    check(32'(msgs.size()), 32'h4);
    for (int i = 0; i < 4; i++)
      check({24'h0, msgs[i]}, {24'h0, exp[i]});
    msgs.delete();
  endtask : s_unsol
  task automatic s_cp;
    @(posedge clk);
    cpReq <= 3'h1;
    @(posedge clk);
    cpReq <= 3'h0;
    repeat (4) @(negedge clk);
    check({29'h0, protRdy}, 32'h0);
    dev_op(PIN_STATUS_OFS, 32'h0, 1'b0);
    check(rv, 32'h011);
    dev_op(PIN_STATUS_OFS, 32'h013, 1'b1);
    check({29'h0, protRdy}, 32'h1);
    check(32'(msgs.size()), 32'h2);
    check({24'h0, msgs[0]}, 32'h81);
    check({24'h0, msgs[1]}, 32'h83);
  endtask : s_cp
  task automatic s_clk;
    dev_op(CLK_PROG_OFS, 32'hffd12345, 1'b1);
    dev_op(CLK_PROG_OFS, 32'h0, 1'b0);
    check(rv, 32'h00112345);
    check({10'h0, clkSel, clkEn, cts}, 32'h00112345);
    dev_op(CLK_PROG_OFS, 32'h002abcde, 1'b1);
    dev_op(CLK_PROG_OFS, 32'h0, 1'b0);
    check(rv, 32'h002abcde);
    check({10'h0, clkSel, clkEn, mVal}, 32'h002abcde);
    check({12'h0, cts}, 32'h00012345);
  endtask : s_clk
  task automatic s_irq;
    axi_rd(H_IRQ_OFS);
    axi_wr(H_MASK_OFS, 32'h3);
    dev_op(20'h650c4, 32'h0, 1'b0);
    check(rv, 32'h0);
    check({31'h0, irq}, 32'h1);
    axi_rd(H_IRQ_OFS);
    check(rv, 32'h3);
    check({31'h0, irq}, 32'h0);
    axi_wr(H_MASK_OFS, 32'h0);
    dev_op(PIN_STATUS_OFS, 32'h0, 1'b0);
    check({31'h0, irq}, 32'h0);
    axi_rd(H_IRQ_OFS);
    check(rv, 32'h1);
    axi_rd(8'h1c);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(8'h1c, 32'h0);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask : s_irq

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    s_reset();
    s_pin();
    s_unsol();
    s_cp();
    s_clk();
    s_irq();
    complete_run();
  end
endmodule : apsc_tb
